// *** logic/sgs_pkg.sv ***
// Purpose: shared constants and types of the safety group status logic
// Assumes: 20 MHz pclk
// Notes:   times in microseconds, cycle counts derived from them
`default_nettype none
package sgs_pkg;
  localparam int CLK_HZ    = 20_000_000;
  localparam int CYC_PER_US = CLK_HZ / 1_000_000;
  localparam int NPAIR     = 4;
  localparam int CONN_MAX  = 15;
  localparam int CONN_STD  = 7;
  localparam int CIDX_W    = 4;
  localparam int ADDR_W    = 10;
  localparam int ID_W      = 16;
  localparam int DISC_W    = 16;
  // flash code timing
  localparam int FLICK_HALF_US  = 50_000;
  localparam int PULSE_HALF_US  = 250_000;
  localparam int FLICK_TOGGLES  = 16;
  localparam int FLICK_HALF_CYC = FLICK_HALF_US * CYC_PER_US;
  localparam int PULSE_HALF_CYC = PULSE_HALF_US * CYC_PER_US;
  // connection watchdog
  localparam int WDOG_US  = 100_000;
  localparam int WDOG_CYC = WDOG_US * CYC_PER_US;
  // discrepancy time reset value
  localparam int DISC_RST_US = 100;
  localparam logic [DISC_W-1:0] DISC_RST_CYC = DISC_W'(DISC_RST_US * CYC_PER_US);
  localparam logic CONTACT_MAKE  = 1'b0;
  localparam logic CONTACT_BREAK = 1'b1;
  typedef enum logic [1:0] {SGS_IN_OFF, SGS_IN_SINGLE, SGS_IN_DUAL} sgs_in_mode_t;
  // controller register map (byte addresses)
  localparam logic [7:0] REG_CTRL    = 8'h00;
  localparam logic [7:0] REG_STATUS  = 8'h04;
  localparam logic [7:0] REG_PAIRCFG = 8'h08;
  localparam logic [7:0] REG_DISC    = 8'h0c;
  localparam logic [7:0] REG_INPUTS  = 8'h10;
  localparam logic [7:0] REG_FRAME   = 8'h14;
  localparam logic [7:0] REG_CSEL    = 8'h18;
  localparam logic [7:0] REG_CCFG    = 8'h1c;
  // CTRL fields
  localparam int CTRL_RUN = 0;
  localparam int CTRL_LNK = 1;
  localparam int CTRL_ACK = 2;
  localparam int CTRL_V15 = 3;
  localparam logic [3:0] CTRL_RST = 4'h1;
  // FRAME / CCFG / STATUS fields
  localparam int FRM_SRC = 4;
  localparam int FRM_MST = 14;
  localparam int FRM_CRC = 15;
  localparam int FRM_ID  = 16;
  localparam int CCFG_ROLE = 10;
  localparam int CCFG_ID   = 16;
  localparam int STAT_CONN = 16;
endpackage
`default_nettype wire

// *** logic/sgs_link_if.sv ***
// Purpose: link between the group logic and its controller
// Assumes: both ends on pclk
// Notes:   config vectors are packed, entry i at [i*W +: W]
`timescale 1ns/10ps
`default_nettype none
interface sgs_link_if;
  logic                                        run;
  logic                                        run_linked;
  logic                                        err_ack;
  logic                                        variant15;
  logic [2*sgs_pkg::NPAIR-1:0]                 pair_mode;
  logic [sgs_pkg::NPAIR-1:0]                   pair_contact;
  logic [sgs_pkg::DISC_W-1:0]                  disc_cyc;
  logic [2*sgs_pkg::NPAIR-1:0]                 in_raw;
  logic [sgs_pkg::CONN_MAX*sgs_pkg::ADDR_W-1:0] conn_addr;
  logic [sgs_pkg::CONN_MAX-1:0]                conn_master;
  logic [sgs_pkg::CONN_MAX*sgs_pkg::ID_W-1:0]  conn_id;
  logic                                        frm_valid;
  logic [sgs_pkg::CIDX_W-1:0]                  frm_conn;
  logic [sgs_pkg::ADDR_W-1:0]                  frm_src;
  logic [sgs_pkg::ID_W-1:0]                    frm_id;
  logic                                        frm_master_msg;
  logic                                        frm_crc_ok;
  logic                                        block_fault_flag;
  logic                                        link_fault_flag;
  logic                                        out_fault_flag;
  logic                                        group_run;
  logic [sgs_pkg::CONN_MAX-1:0]                conn_err;
  modport dev (input run, run_linked, err_ack, variant15, pair_mode, pair_contact, disc_cyc, in_raw,
               conn_addr, conn_master, conn_id, frm_valid, frm_conn, frm_src, frm_id, frm_master_msg,
               frm_crc_ok,
               output block_fault_flag, link_fault_flag, out_fault_flag, group_run, conn_err);
  modport ctl (output run, run_linked, err_ack, variant15, pair_mode, pair_contact, disc_cyc, in_raw,
               conn_addr, conn_master, conn_id, frm_valid, frm_conn, frm_src, frm_id, frm_master_msg,
               frm_crc_ok,
               input block_fault_flag, link_fault_flag, out_fault_flag, group_run, conn_err);
endinterface
`default_nettype wire

// *** logic/sgs_pair_chk.sv ***
// Purpose: qualifies one function-block input pair
// Assumes: inputs already on pclk
// Notes:   error latches until clr arrives with the pair in agreement
`timescale 1ns/10ps
`default_nettype none
module sgs_pair_chk (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        in_a,
  input  wire logic                        in_b,
  input  wire logic [1:0]                  mode,
  input  wire logic                        contact,
  input  wire logic [sgs_pkg::DISC_W-1:0]  disc_cyc,
  input  wire logic                        clr,
  output logic                             act,
  output logic                             err
);
  logic                       dual;
  logic                       b_exp;
  logic                       mism;
  logic [sgs_pkg::DISC_W-1:0] cnt_q;
  logic [sgs_pkg::DISC_W-1:0] cnt_d;
  logic                       err_q;
  logic                       err_d;

  always_comb
  begin
    dual  = (mode == sgs_pkg::SGS_IN_DUAL);
    // break contact pairs are antivalent: b is compared inverted
    b_exp = in_b ^ (contact == sgs_pkg::CONTACT_BREAK);
    mism  = dual && (in_a != b_exp);
    cnt_d = '0;
    if (mism && cnt_q != '1)
      cnt_d = cnt_q + 1'b1;
    else if (mism)
      cnt_d = cnt_q;
    err_d = (mism && cnt_q >= disc_cyc) || (err_q && !(clr && !mism));
    case (mode)
      sgs_pkg::SGS_IN_SINGLE: act = (in_a ^ contact) | (in_b ^ contact);
      sgs_pkg::SGS_IN_DUAL:   act = in_a & b_exp & !err_q;
      default:                act = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_q <= '0;
      err_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      err_q <= err_d;
    end
  end

  assign err = err_q;
endmodule
`default_nettype wire

// *** logic/sgs_group_dev.sv ***
// Purpose: status and control logic of one safety group
// Assumes: controller on pclk drives the link; out_fault_in comes from pins
// Notes:   outputs are held low (safe) from the cycle after the group stops running
// Notes on behaviour
// - run true or unlinked executes blocks
// - run false stops blocks, outputs safe (code: only while run_linked is set; unlinked, blocks keep running)
// - low-high-low on acknowledge clears errors
// - block fault flag while any block errs
// - link fault flag while any connection errs
// - output fault flag while local output faulty
// - input deactivated or single-channel independent
// - two-channel pair checked equal or opposite
// - discrepancy time bounds pair switching skew
// - make or break sets active level
// - seven or fifteen connections by variant
// - one connection per partner terminal
// - master and slave exchange opposite messages
// - subscriber id must match publisher id
// - frames from foreign addresses rejected
// - green steady while no block fault and no link fault
// - flicker then 1, 2 or 3 pulses
// - falling acknowledge edge clears indicated errors
// - connection fault switches off the group
`timescale 1ns/10ps
`default_nettype none
module sgs_group_dev #(
  parameter int FLICK_HALF_CYC = sgs_pkg::FLICK_HALF_CYC,
  parameter int PULSE_HALF_CYC = sgs_pkg::PULSE_HALF_CYC,
  parameter int WDOG_CYC       = sgs_pkg::WDOG_CYC
) (
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  sgs_link_if.dev                         lnk,
  input  wire logic [sgs_pkg::NPAIR-1:0]  out_fault_in,
  output logic [sgs_pkg::NPAIR-1:0]       fb_out,
  output logic                            green_status_indicator
);
  localparam int NP = sgs_pkg::NPAIR;
  localparam int NC = sgs_pkg::CONN_MAX;
  localparam int AW = sgs_pkg::ADDR_W;
  localparam int IW = sgs_pkg::ID_W;

  typedef enum logic [1:0] {ST_STEADY, ST_FLICK, ST_PAUSE, ST_PULSE} sgs_led_st_t;

  logic [NP-1:0] of_s1_q;
  logic [NP-1:0] of_s2_q;
  logic          ack_prev_q;
  logic          ack_armed_q;
  logic          ack_armed_d;
  logic          ack_clr;
  logic          run_eff;
  logic [NP-1:0] pair_act;
  logic [NP-1:0] pair_err;
  logic [NC-1:0] conn_err_q;
  logic [NC-1:0] conn_on;
  logic          out_fault_q;
  logic          out_fault_d;
  logic          grp_run_q;
  logic          grp_run_d;
  logic [NP-1:0] fb_out_q;
  logic [NP-1:0] fb_out_d;

  // local output fault pins cross into pclk
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      of_s1_q <= '0;
      of_s2_q <= '0;
    end
    else
    begin
      of_s1_q <= out_fault_in;
      of_s2_q <= of_s1_q;
    end
  end

  // acknowledge: a rise arms, the following fall clears
  always_comb
  begin
    ack_clr     = ack_armed_q && ack_prev_q && !lnk.err_ack;
    ack_armed_d = ack_armed_q;
    if (!ack_prev_q && lnk.err_ack)
      ack_armed_d = 1'b1;
    else if (ack_clr)
      ack_armed_d = 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ack_prev_q  <= 1'b0;
      ack_armed_q <= 1'b0;
    end
    else
    begin
      ack_prev_q  <= lnk.err_ack;
      ack_armed_q <= ack_armed_d;
    end
  end

  genvar gp;
  generate
    for (gp = 0; gp < NP; gp++)
    begin : g_pair
      sgs_pair_chk u_chk (
        .pclk     (pclk),
        .presetn  (presetn),
        .in_a     (lnk.in_raw[2*gp]),
        .in_b     (lnk.in_raw[2*gp+1]),
        .mode     (lnk.pair_mode[2*gp +: 2]),
        .contact  (lnk.pair_contact[gp]),
        .disc_cyc (lnk.disc_cyc),
        .clr      (ack_clr),
        .act      (pair_act[gp]),
        .err      (pair_err[gp])
      );
    end
  endgenerate

  // connections: address, id and role checks plus a receive watchdog
  genvar gc;
  generate
    for (gc = 0; gc < NC; gc++)
    begin : g_conn
      logic [31:0] wd_q;
      logic [31:0] wd_d;
      logic        hit;
      logic        good;
      logic        dup;
      logic        cause;
      logic        err_d;
      always_comb
      begin
        conn_on[gc] = lnk.variant15 || (gc < sgs_pkg::CONN_STD);
        hit  = lnk.frm_valid && (lnk.frm_conn == sgs_pkg::CIDX_W'(gc));
        good = lnk.frm_src == lnk.conn_addr[gc*AW +: AW]
            && lnk.frm_id == lnk.conn_id[gc*IW +: IW]
            && lnk.frm_master_msg == !lnk.conn_master[gc]
            && lnk.frm_crc_ok;
        dup = (lnk.conn_addr[gc*AW +: AW] == '0);
        for (int j = 0; j < NC; j++)
          if (j != gc && (lnk.variant15 || j < sgs_pkg::CONN_STD)
              && lnk.conn_addr[j*AW +: AW] == lnk.conn_addr[gc*AW +: AW])
            dup = 1'b1;
        wd_d = wd_q;
        if (hit && good)
          wd_d = '0;
        else if (wd_q < 32'(WDOG_CYC))
          wd_d = wd_q + 32'd1;
        cause = conn_on[gc] && ((hit && !good) || dup || wd_q >= 32'(WDOG_CYC));
        // a new cause wins over the acknowledge
        err_d = cause || (conn_err_q[gc] && !(ack_clr && !dup && wd_q < 32'(WDOG_CYC)));
        if (!conn_on[gc])
          err_d = 1'b0;
      end
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          wd_q           <= '0;
          conn_err_q[gc] <= 1'b0;
        end
        else
        begin
          wd_q           <= wd_d;
          conn_err_q[gc] <= err_d;
        end
      end
    end
  endgenerate

  // group run and gated block outputs
  always_comb
  begin
    run_eff     = !lnk.run_linked || lnk.run;
    grp_run_d   = run_eff && !(|conn_err_q);
    fb_out_d    = grp_run_q ? (pair_act & ~pair_err) : '0;
    out_fault_d = (|of_s2_q) || (out_fault_q && !ack_clr);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      grp_run_q   <= 1'b0;
      fb_out_q    <= '0;
      out_fault_q <= 1'b0;
    end
    else
    begin
      grp_run_q   <= grp_run_d;
      fb_out_q    <= fb_out_d;
      out_fault_q <= out_fault_d;
    end
  end

  assign fb_out               = fb_out_q;
  assign lnk.group_run        = grp_run_q;
  assign lnk.block_fault_flag = |pair_err;
  assign lnk.link_fault_flag  = |conn_err_q;
  assign lnk.out_fault_flag   = out_fault_q;
  assign lnk.conn_err         = conn_err_q;

  // flash code generator
  sgs_led_st_t st_q;
  sgs_led_st_t st_d;
  logic [31:0] tmr_q;
  logic [31:0] tmr_d;
  logic [4:0]  tog_q;
  logic [4:0]  tog_d;
  logic [1:0]  npls_q;
  logic [1:0]  npls_d;
  logic [1:0]  code_q;
  logic [1:0]  code_d;
  logic        led_q;
  logic        led_d;
  logic [1:0]  code_now;
  logic        tmo;

  always_comb
  begin
    code_now = {lnk.block_fault_flag, lnk.link_fault_flag};
    st_d   = st_q;
    tmr_d  = tmr_q + 32'd1;
    tog_d  = tog_q;
    npls_d = npls_q;
    code_d = code_q;
    led_d  = led_q;
    tmo    = 1'b0;
    case (st_q)
      ST_STEADY:
      begin
        led_d = 1'b1;
        tmr_d = '0;
        if (code_now != 2'h0)
        begin
          st_d   = ST_FLICK;
          tog_d  = '0;
          code_d = code_now;
        end
      end
      ST_FLICK:
      begin
        tmo = tmr_q >= 32'(FLICK_HALF_CYC - 1);
        if (tmo)
        begin
          tmr_d = '0;
          led_d = !led_q;
          tog_d = tog_q + 5'd1;
          if (tog_q == 5'(sgs_pkg::FLICK_TOGGLES - 1))
          begin
            st_d   = ST_PAUSE;
            led_d  = 1'b0;
            npls_d = '0;
          end
        end
      end
      ST_PAUSE:
      begin
        tmo = tmr_q >= 32'(PULSE_HALF_CYC - 1);
        if (tmo)
        begin
          tmr_d = '0;
          if (npls_q < code_q)
          begin
            st_d  = ST_PULSE;
            led_d = 1'b1;
          end
          else if (code_now != 2'h0)
          begin
            // code resampled once per round so a pattern is never cut short
            st_d   = ST_FLICK;
            tog_d  = '0;
            code_d = code_now;
          end
          else
            st_d = ST_STEADY;
        end
      end
      ST_PULSE:
      begin
        tmo = tmr_q >= 32'(PULSE_HALF_CYC - 1);
        if (tmo)
        begin
          tmr_d  = '0;
          led_d  = 1'b0;
          npls_d = npls_q + 2'd1;
          st_d   = ST_PAUSE;
        end
      end
      default:
        st_d = ST_STEADY;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q   <= ST_STEADY;
      tmr_q  <= '0;
      tog_q  <= '0;
      npls_q <= '0;
      code_q <= '0;
      led_q  <= 1'b1;
    end
    else
    begin
      st_q   <= st_d;
      tmr_q  <= tmr_d;
      tog_q  <= tog_d;
      npls_q <= npls_d;
      code_q <= code_d;
      led_q  <= led_d;
    end
  end

  assign green_status_indicator = led_q;
endmodule
`default_nettype wire

// *** logic/sgs_group_ctl.sv ***
// Purpose: controller end; APB registers drive the group link
// Assumes: APB3 slave, zero wait states
// Notes:   read data captured in the setup cycle
`timescale 1ns/10ps
`default_nettype none
module sgs_group_ctl (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  sgs_link_if.ctl          lnk
);
  localparam int NP = sgs_pkg::NPAIR;
  localparam int NC = sgs_pkg::CONN_MAX;
  localparam int AW = sgs_pkg::ADDR_W;
  localparam int IW = sgs_pkg::ID_W;

  logic [3:0]               ctrl_q, ctrl_d;
  logic [3*NP-1:0]          pcfg_q, pcfg_d;
  logic [sgs_pkg::DISC_W-1:0] disc_q, disc_d;
  logic [2*NP-1:0]          inr_q, inr_d;
  logic [31:0]              frm_q, frm_d;
  logic                     fv_q, fv_d;
  logic [3:0]               sel_q, sel_d;
  logic [AW-1:0]            caddr_q [NC];
  logic [AW-1:0]            caddr_d [NC];
  logic [IW-1:0]            cid_q [NC];
  logic [IW-1:0]            cid_d [NC];
  logic [NC-1:0]            crole_q, crole_d;
  logic [31:0]              rd_q, rd_d;
  logic                     err_q, err_d;
  logic                     wr;

  always_comb
  begin
    wr      = psel && penable && pwrite;
    ctrl_d  = ctrl_q;
    pcfg_d  = pcfg_q;
    disc_d  = disc_q;
    inr_d   = inr_q;
    frm_d   = frm_q;
    fv_d    = 1'b0;
    sel_d   = sel_q;
    caddr_d = caddr_q;
    cid_d   = cid_q;
    crole_d = crole_q;
    rd_d    = rd_q;
    err_d   = err_q;
    if (psel && !penable)
    begin
      rd_d  = '0;
      err_d = 1'b0;
      case (paddr)
        sgs_pkg::REG_CTRL:    rd_d[3:0] = ctrl_q;
        sgs_pkg::REG_STATUS:  rd_d = {1'b0, lnk.conn_err, 12'h000, lnk.group_run,
                                      lnk.out_fault_flag, lnk.link_fault_flag, lnk.block_fault_flag};
        sgs_pkg::REG_PAIRCFG: rd_d[3*NP-1:0] = pcfg_q;
        sgs_pkg::REG_DISC:    rd_d[sgs_pkg::DISC_W-1:0] = disc_q;
        sgs_pkg::REG_INPUTS:  rd_d[2*NP-1:0] = inr_q;
        sgs_pkg::REG_FRAME:   rd_d = frm_q;
        sgs_pkg::REG_CSEL:    rd_d[3:0] = sel_q;
        sgs_pkg::REG_CCFG:    rd_d = {cid_q[sel_q], 5'h00, crole_q[sel_q], caddr_q[sel_q]};
        default:              err_d = 1'b1;
      endcase
    end
    if (wr)
    begin
      case (paddr)
        sgs_pkg::REG_CTRL:    ctrl_d = pwdata[3:0];
        sgs_pkg::REG_PAIRCFG: pcfg_d = pwdata[3*NP-1:0];
        sgs_pkg::REG_DISC:    disc_d = pwdata[sgs_pkg::DISC_W-1:0];
        sgs_pkg::REG_INPUTS:  inr_d = pwdata[2*NP-1:0];
        sgs_pkg::REG_FRAME:
        begin
          frm_d = pwdata;
          fv_d  = 1'b1;
        end
        sgs_pkg::REG_CSEL:    sel_d = (pwdata[3:0] < 4'(NC)) ? pwdata[3:0] : sel_q;
        sgs_pkg::REG_CCFG:
        begin
          caddr_d[sel_q] = pwdata[AW-1:0];
          crole_d[sel_q] = pwdata[sgs_pkg::CCFG_ROLE];
          cid_d[sel_q]   = pwdata[sgs_pkg::CCFG_ID +: IW];
        end
        default:              ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q  <= sgs_pkg::CTRL_RST;
      pcfg_q  <= '0;
      disc_q  <= sgs_pkg::DISC_RST_CYC;
      inr_q   <= '0;
      frm_q   <= '0;
      fv_q    <= 1'b0;
      sel_q   <= '0;
      crole_q <= '0;
      rd_q    <= '0;
      err_q   <= 1'b0;
      for (int i = 0; i < NC; i++)
      begin
        caddr_q[i] <= '0;
        cid_q[i]   <= '0;
      end
    end
    else
    begin
      ctrl_q  <= ctrl_d;
      pcfg_q  <= pcfg_d;
      disc_q  <= disc_d;
      inr_q   <= inr_d;
      frm_q   <= frm_d;
      fv_q    <= fv_d;
      sel_q   <= sel_d;
      crole_q <= crole_d;
      rd_q    <= rd_d;
      err_q   <= err_d;
      caddr_q <= caddr_d;
      cid_q   <= cid_d;
    end
  end

  assign prdata  = rd_q;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && err_q;

  // software sequences the acknowledge low-high-low through CTRL
  assign lnk.run            = ctrl_q[sgs_pkg::CTRL_RUN];
  assign lnk.run_linked     = ctrl_q[sgs_pkg::CTRL_LNK];
  assign lnk.err_ack        = ctrl_q[sgs_pkg::CTRL_ACK];
  assign lnk.variant15      = ctrl_q[sgs_pkg::CTRL_V15];
  assign lnk.pair_mode      = pcfg_q[2*NP-1:0];
  assign lnk.pair_contact   = pcfg_q[3*NP-1:2*NP];
  assign lnk.disc_cyc       = disc_q;
  assign lnk.in_raw         = inr_q;
  assign lnk.conn_master    = crole_q;
  assign lnk.frm_valid      = fv_q;
  assign lnk.frm_conn       = frm_q[3:0];
  assign lnk.frm_src        = frm_q[sgs_pkg::FRM_SRC +: AW];
  assign lnk.frm_master_msg = frm_q[sgs_pkg::FRM_MST];
  assign lnk.frm_crc_ok     = frm_q[sgs_pkg::FRM_CRC];
  assign lnk.frm_id         = frm_q[sgs_pkg::FRM_ID +: IW];

  genvar gc;
  generate
    for (gc = 0; gc < NC; gc++)
    begin : g_cfg
      assign lnk.conn_addr[gc*AW +: AW] = caddr_q[gc];
      assign lnk.conn_id[gc*IW +: IW]   = cid_q[gc];
    end
  endgenerate
endmodule
`default_nettype wire

// *** sim/sgs_link_assertions.sv ***
// Purpose: checks on the group link
// Assumes: one clock domain
// Notes: sees the link signals only
`timescale 1ns/10ps
`default_nettype none
module sgs_link_assertions (
  input wire logic                         pclk,
  input wire logic                         presetn,
  input wire logic                         run,
  input wire logic                         run_linked,
  input wire logic                         err_ack,
  input wire logic                         frm_valid,
  input wire logic [sgs_pkg::CIDX_W-1:0]   frm_conn,
  input wire logic                         frm_crc_ok,
  input wire logic                         block_fault_flag,
  input wire logic                         link_fault_flag,
  input wire logic                         out_fault_flag,
  input wire logic                         group_run,
  input wire logic [sgs_pkg::CONN_MAX-1:0] conn_err
);
  logic live_q;
  // release lands on an edge: attempts start one edge later so none sees reset state
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      live_q <= 1'b0;
    else
      live_q <= 1'b1;
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn || !live_q);
  // a flag may only drop the cycle after acknowledge falls
  sequence ack_seen;
    !$past(err_ack) && $past(err_ack, 2);
  endsequence
  a_link_or: assert property (link_fault_flag == |conn_err)
    else $error("link flag differs from connection errors");
  a_run_stop: assert property (!run && run_linked |=> !group_run)
    else $error("group kept running with run low");
  a_run_go: assert property ((run || !run_linked) && conn_err == 15'h0 |=> group_run)
    else $error("group not running");
  a_conn_stop: assert property (conn_err != 15'h0 |=> !group_run)
    else $error("group ran with a connection error");
  a_bad_frame: assert property (frm_valid && frm_conn < 4'h7 && !frm_crc_ok |=> conn_err[frm_conn])
    else $error("bad frame not flagged");
  a_link_hold: assert property ($fell(link_fault_flag) |-> ack_seen)
    else $error("link flag dropped without acknowledge");
  a_block_hold: assert property ($fell(block_fault_flag) |-> ack_seen)
    else $error("block flag dropped without acknowledge");
  a_out_hold: assert property ($fell(out_fault_flag) |-> ack_seen)
    else $error("output flag dropped without acknowledge");
endmodule
`default_nettype wire

// *** sim/safety_group_status_logic_bench.sv ***
// Purpose: bench joining controller and group ends
// Assumes: shortened flash and watchdog counts
// Notes: flash code judged by rises over one period
`timescale 1ns/10ps
`default_nettype none
module safety_group_status_logic_bench;
  localparam int FH = 4;
  localparam int PH = 8;
  localparam int WD = 200;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, green;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, r, v;
  logic [3:0]  out_fault_in, fb_out;
  logic [31:0] bad [4] = '{32'h10, 32'h4000, 32'h8000, 32'h10000};
  int          mismatches, samples_checked, cyc, k, j;
  sgs_link_if sgs_link_if_i ();
  sgs_group_dev #(.FLICK_HALF_CYC(FH), .PULSE_HALF_CYC(PH), .WDOG_CYC(WD)) sgs_group_dev_i (.pclk(pclk),
    .presetn(presetn), .lnk(sgs_link_if_i), .out_fault_in(out_fault_in), .fb_out(fb_out),
    .green_status_indicator(green));
  sgs_group_ctl sgs_group_ctl_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .lnk(sgs_link_if_i));
  sgs_link_assertions sgs_link_assertions_i (.pclk(pclk), .presetn(presetn), .run(sgs_link_if_i.run),
    .run_linked(sgs_link_if_i.run_linked), .err_ack(sgs_link_if_i.err_ack),
    .frm_valid(sgs_link_if_i.frm_valid), .frm_conn(sgs_link_if_i.frm_conn),
    .frm_crc_ok(sgs_link_if_i.frm_crc_ok), .block_fault_flag(sgs_link_if_i.block_fault_flag),
    .link_fault_flag(sgs_link_if_i.link_fault_flag), .out_fault_flag(sgs_link_if_i.out_fault_flag),
    .group_run(sgs_link_if_i.group_run), .conn_err(sgs_link_if_i.conn_err));
  function automatic logic [31:0] frm(input int i);
    return {16'(i + 16'h30), 2'h3, 10'(i + 1), 4'(i)};
  endfunction
  task automatic close_out();
    if (mismatches == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // idle cycle first so psel is never assigned twice in one step
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    r = w ? {31'h0, pslverr} : prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(a, 1'b0, 32'h0);
    chk(r, e);
  endtask
  task automatic feed();
    for (int i = 0; i < 7; i++)
      apb(sgs_pkg::REG_FRAME, 1'b1, frm(i));
  endtask
  task automatic heal();
    feed();
    apb(sgs_pkg::REG_CTRL, 1'b1, 32'h5);
    apb(sgs_pkg::REG_CTRL, 1'b1, 32'h1);
    feed();
  endtask
  task automatic leds(input int n);
    int   rises;
    logic g;
    logic lo;
    // skip a round: the one entered from steady starts lit and has one rise less
    repeat (16 * FH + PH + 2 * PH * n) @(posedge pclk);
    feed();
    rises = 0;
    g = green;
    lo = green;
    repeat (16 * FH + PH + 2 * PH * n)
    begin
      @(posedge pclk);
      rises += int'(green & !g);
      g = green;
      lo &= green;
    end
    chk(rises, n > 0 ? 8 + n : 0);
    chk(32'(lo), 32'(n == 0));
  endtask
  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      mismatches++;
      close_out();
    end
  end
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata, out_fault_in} = '0;
    {mismatches, samples_checked, cyc} = '0;
    r = $urandom(59);
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rd(sgs_pkg::REG_CTRL, 32'h1);
    rd(sgs_pkg::REG_DISC, 32'h7d0);
    apb(8'h20, 1'b1, 32'h0);
    chk(r, 32'h1);
    repeat (WD) @(posedge pclk);
    rd(sgs_pkg::REG_STATUS, 32'h007f0002);
    leds(1);
    for (k = 0; k < 7; k++)
    begin
      apb(sgs_pkg::REG_CSEL, 1'b1, k);
      apb(sgs_pkg::REG_CCFG, 1'b1, {16'(k + 16'h30), 6'h0, 10'(k + 1)});
    end
    apb(sgs_pkg::REG_INPUTS, 1'b1, 32'h8);
    apb(sgs_pkg::REG_PAIRCFG, 1'b1, 32'h21a);
    apb(sgs_pkg::REG_DISC, 1'b1, 32'h3);
    heal();
    rd(sgs_pkg::REG_STATUS, 32'h8);
    leds(0);
    repeat (4)
    begin
      v = $urandom & 32'hff;
      v[1] = v[0];
      v[3] = !v[2];
      apb(sgs_pkg::REG_INPUTS, 1'b1, v);
      repeat (4) @(posedge pclk);
      chk(32'(fb_out), {28'h0, 1'b0, v[4] | v[5], v[2], v[0]});
      feed();
    end
    apb(sgs_pkg::REG_INPUTS, 1'b1, 32'h17);
    apb(sgs_pkg::REG_CTRL, 1'b1, 32'h2);
    repeat (4) @(posedge pclk);
    chk(32'(fb_out), 32'h0);
    apb(sgs_pkg::REG_CTRL, 1'b1, 32'h3);
    repeat (4) @(posedge pclk);
    chk(32'(fb_out), 32'h7);
    apb(sgs_pkg::REG_INPUTS, 1'b1, 32'h9);
    repeat (8) @(posedge pclk);
    feed();
    rd(sgs_pkg::REG_STATUS, 32'h9);
    leds(2);
    repeat (WD) @(posedge pclk);
    leds(3);
    // links time out again, so the acknowledge below cannot clear them
    repeat (WD) @(posedge pclk);
    apb(sgs_pkg::REG_INPUTS, 1'b1, 32'h8);
    out_fault_in <= 4'h4;
    repeat (6) @(posedge pclk);
    out_fault_in <= 4'h0;
    rd(sgs_pkg::REG_STATUS, 32'h007f0007);
    apb(sgs_pkg::REG_CTRL, 1'b1, 32'h5);
    apb(sgs_pkg::REG_CTRL, 1'b1, 32'h1);
    rd(sgs_pkg::REG_STATUS, 32'h007f0002);
    for (k = 0; k < 4; k++)
    begin
      heal();
      j = $urandom % 7;
      apb(sgs_pkg::REG_FRAME, 1'b1, frm(j) ^ bad[k]);
      // group run drops two edges after the frame
      repeat (2) @(posedge pclk);
      rd(sgs_pkg::REG_STATUS, 32'h2 | (32'h10000 << j));
    end
    // fifteen connections: the eight unset ones carry address zero
    apb(sgs_pkg::REG_CTRL, 1'b1, 32'h9);
    repeat (2) @(posedge pclk);
    rd(sgs_pkg::REG_STATUS, 32'h7f800002 | (32'h10000 << j));
    close_out();
  end
endmodule
`default_nettype wire
